// file: diskette_adapter_control.sv
// Drive control register and controller host interface of the diskette adapter
`timescale 1ns/1ps
`default_nettype none
module diskette_adapter_control
  import diskette_adapter_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [9:0]            io_addr_i,
  input  wire logic                  io_wr_i,
  input  wire logic                  io_rd_i,
  input  wire logic [DATA_WIDTH-1:0] io_wdata_i,
  output logic      [DATA_WIDTH-1:0] io_rdata_o,
  output logic                       io_rdata_en_o,
  input  wire logic                  dma_ack_i,
  input  wire logic                  disk_index_i,
  output logic                       irq_o,
  output logic                       irq_oe_o,
  output logic                       dma_req_o,
  output logic                       dma_req_oe_o,
  output logic                       drive_sel_a_o,
  output logic                       drive_sel_b_o,
  output logic                       motor_a_o,
  output logic                       motor_b_o,
  output logic                       ctrl_reset_o,
  output logic      [3:0]            command_code_o
);
  logic [7:0]            drive_control_ff;
  phase_e                phase_ff;
  logic [3:0]            cmd_len_ff;
  logic [3:0]            cmd_cnt_ff;
  logic [3:0]            res_cnt_ff;
  logic [3:0]            command_ff;
  logic                  pend_irq_ff;
  logic                  ctrl_rst;
  logic                  wr_dcr;
  logic                  wr_data;
  logic                  rd_data;
  logic                  rd_status;
  logic                  exec_done;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [DATA_WIDTH-1:0] fifo_out_data;
  logic                  fifo_push;
  logic                  fifo_pop;
  logic [7:0]            status_byte;
  logic                  gate;

  assign ctrl_rst  = !drive_control_ff[NOT_RESET_BIT];
  assign gate      = drive_control_ff[REQ_GATE_BIT];
  assign wr_dcr    = io_wr_i && (io_addr_i == DRIVE_CONTROL_ADDR);
  assign wr_data   = io_wr_i && (io_addr_i == DATA_STACK_ADDR);
  assign rd_data   = io_rd_i && (io_addr_i == DATA_STACK_ADDR);
  assign rd_status = io_rd_i && (io_addr_i == MAIN_STATUS_ADDR);

  // Drive control register; no read path exists on purpose
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_control_ff <= DRIVE_CONTROL_RST;
    end else if (wr_dcr) begin
      drive_control_ff <= io_wdata_i;
    end
  end

  // Drive lines: only 00 and 01 decode, each needs its motor on
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_sel_a_o <= 1'b0;
      drive_sel_b_o <= 1'b0;
      motor_a_o     <= 1'b0;
      motor_b_o     <= 1'b0;
      ctrl_reset_o  <= 1'b1;
    end else begin
      drive_sel_a_o <= (drive_control_ff[SEL_HI_BIT:SEL_LO_BIT] == 2'h0)
                       && drive_control_ff[MOTOR_A_BIT];
      drive_sel_b_o <= (drive_control_ff[SEL_HI_BIT:SEL_LO_BIT] == 2'h1)
                       && drive_control_ff[MOTOR_B_BIT];
      motor_a_o     <= drive_control_ff[MOTOR_A_BIT];
      motor_b_o     <= drive_control_ff[MOTOR_B_BIT];
      ctrl_reset_o  <= ctrl_rst;
    end
  end

  // Command length per opcode; unknown opcodes take two bytes
  function automatic logic [3:0] cmd_len(input logic [3:0] op);
    logic [3:0] len;
    len = 4'h1;
    if (op != 4'h0) begin
      len = (op < 4'h8) ? 4'h9 : 4'h2;
    end
    return len;
  endfunction

  // Result bytes wait in the FIFO until the host reads them
  // A controller reset in mid-execution blocks further pushes but leaves bytes already pushed behind for the next command
  assign fifo_push = (phase_ff == PH_EXECUTE) && !ctrl_rst && exec_done && fifo_in_ready;
  assign fifo_pop  = rd_data && (phase_ff == PH_RESULT) && fifo_out_valid;

  // Each execution byte completes on the DMA acknowledge or an index pulse
  assign exec_done = dma_ack_i || disk_index_i;

  // Phase sequencer held idle while the controller is in reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff   <= PH_COMMAND;
      cmd_len_ff <= 4'h1;
      cmd_cnt_ff <= 4'h0;
      res_cnt_ff <= 4'h0;
      command_ff <= 4'h0;
    end else if (ctrl_rst) begin
      phase_ff   <= PH_COMMAND;
      cmd_cnt_ff <= 4'h0;
      res_cnt_ff <= 4'h0;
    end else begin
      case (phase_ff)
        PH_COMMAND: begin
          if (wr_data) begin
            if (cmd_cnt_ff == 4'h0) begin
              command_ff <= (io_wdata_i[3:0] < 4'(NUM_COMMANDS)) ? io_wdata_i[3:0] : 4'h0;
              cmd_len_ff <= cmd_len(io_wdata_i[3:0]);
            end
            if ((cmd_cnt_ff == 4'h0 && cmd_len(io_wdata_i[3:0]) == 4'h1) ||
                (cmd_cnt_ff != 4'h0 && cmd_cnt_ff + 4'h1 == cmd_len_ff)) begin
              phase_ff   <= PH_EXECUTE;
              cmd_cnt_ff <= 4'h0;
            end else begin
              cmd_cnt_ff <= cmd_cnt_ff + 4'h1;
            end
          end
        end
        PH_EXECUTE: begin
          // Stalls while the result buffer is full
          if (fifo_push) begin
            if (res_cnt_ff + 4'h1 == RESULT_BYTES) begin
              phase_ff   <= PH_RESULT;
              res_cnt_ff <= 4'h0;
            end else begin
              res_cnt_ff <= res_cnt_ff + 4'h1;
            end
          end
        end
        PH_RESULT: begin
          if (fifo_pop && res_cnt_ff + 4'h1 == RESULT_BYTES) begin
            phase_ff   <= PH_COMMAND;
            res_cnt_ff <= 4'h0;
          end else if (fifo_pop) begin
            res_cnt_ff <= res_cnt_ff + 4'h1;
          end
        end
        default: phase_ff <= PH_COMMAND;
      endcase
    end
  end

  byte_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (DEPTH)
  ) u_result_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({command_ff, res_cnt_ff}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rd_data && phase_ff == PH_RESULT),
    .out_data_o  (fifo_out_data)
  );

  // Main status: request-for-master, direction, execution, busy
  always_comb begin
    status_byte = 8'h00;
    status_byte[MSR_RQM_BIT]  = !ctrl_rst && ((phase_ff == PH_COMMAND) ||
                                 (phase_ff == PH_RESULT && fifo_out_valid));
    status_byte[MSR_DIO_BIT]  = (phase_ff == PH_RESULT);
    status_byte[MSR_EXEC_BIT] = (phase_ff == PH_EXECUTE);
    status_byte[MSR_BUSY_BIT] = (phase_ff != PH_COMMAND) || (cmd_cnt_ff != 4'h0);
  end

  // Read data: one stacked byte or the status, presented for one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o    <= 8'h00;
      io_rdata_en_o <= 1'b0;
    end else begin
      io_rdata_en_o <= rd_status || rd_data;
      if (rd_status) begin
        io_rdata_o <= status_byte;
      end else if (rd_data) begin
        io_rdata_o <= fifo_out_valid && phase_ff == PH_RESULT ? fifo_out_data : 8'h00;
      end
    end
  end

  // Completion flag: set when results are ready, cleared by reading or reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_irq_ff <= 1'b0;
    end else if (phase_ff == PH_EXECUTE && fifo_push &&
                 res_cnt_ff + 4'h1 == RESULT_BYTES) begin
      pend_irq_ff <= 1'b1;
    end else if (rd_data || ctrl_rst) begin
      pend_irq_ff <= 1'b0;
    end
  end

  // Bus request drivers enabled only when the gate bit is set
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o          <= 1'b0;
      irq_oe_o       <= 1'b0;
      dma_req_o      <= 1'b0;
      dma_req_oe_o   <= 1'b0;
      command_code_o <= 4'h0;
    end else begin
      irq_oe_o       <= gate;
      dma_req_oe_o   <= gate;
      irq_o          <= gate && pend_irq_ff;
      dma_req_o      <= gate && !ctrl_rst && phase_ff == PH_EXECUTE && fifo_in_ready;
      command_code_o <= command_ff;
    end
  end

  // Reset leaves the register and every drive line but the controller reset switched off
  a_reset_clears: assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> drive_control_ff == 8'h00)
    else $error("drive control not cleared by reset");
  a_reset_pins: assert property (@(posedge sys_clk_i)
    $fell(rst_i) |-> ctrl_reset_o && !motor_a_o && !motor_b_o && !irq_oe_o && !dma_req_oe_o)
    else $error("drive lines not cleared by reset");
  // Writes land in the register; a read of its address gets no answer
  a_dcr_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_dcr |=> drive_control_ff == $past(io_wdata_i))
    else $error("drive control write lost");
  a_dcr_no_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_rd_i && io_addr_i == DRIVE_CONTROL_ADDR) |=> !io_rdata_en_o)
    else $error("drive control register answered a read");
  // At most one select, and only for a drive whose motor runs
  a_sel_a_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (drive_control_ff[1:0] == 2'h0 && drive_control_ff[MOTOR_A_BIT]) |=> drive_sel_a_o)
    else $error("drive A not selected");
  a_sel_b_decode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (drive_control_ff[1:0] == 2'h1 && drive_control_ff[MOTOR_B_BIT]) |=> drive_sel_b_o)
    else $error("drive B not selected");
  a_sel_a_motor: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    drive_sel_a_o |-> motor_a_o)
    else $error("drive A selected with motor off");
  a_sel_b_motor: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    drive_sel_b_o |-> motor_b_o)
    else $error("drive B selected with motor off");
  a_one_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !(drive_sel_a_o && drive_sel_b_o))
    else $error("two drives selected at once");
  a_sel_none: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    drive_control_ff[1] |=> !drive_sel_a_o && !drive_sel_b_o)
    else $error("undefined pattern selected a drive");
  // Controller reset and the shared request gate
  a_ctrl_held: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ctrl_rst |=> ctrl_reset_o && phase_ff == PH_COMMAND)
    else $error("controller not held in reset");
  a_gate_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !gate |=> !irq_oe_o && !dma_req_oe_o && !irq_o && !dma_req_o)
    else $error("requests driven while gated off");
  a_irq_source: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    irq_o |-> irq_oe_o && $past(pend_irq_ff))
    else $error("interrupt without a pending completion");
  a_dma_exec: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dma_req_o |-> dma_req_oe_o && $past(phase_ff == PH_EXECUTE))
    else $error("DMA request outside execution");
  // Status is never written; the stack hands out one byte per read
  a_status_ro: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (io_wr_i && io_addr_i == MAIN_STATUS_ADDR && phase_ff == PH_COMMAND && !ctrl_rst)
      |=> $stable(phase_ff) && $stable(cmd_cnt_ff))
    else $error("status write changed the controller");
  a_read_status: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_status |=> io_rdata_en_o)
    else $error("status read not answered");
  a_one_byte: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_data && phase_ff != PH_RESULT) |=> io_rdata_en_o && io_rdata_o == 8'h00)
    else $error("data read outside result phase gave a byte");
  // Phase order: command bytes, then execution, then results
  sequence s_short_command;
    phase_ff == PH_COMMAND && !ctrl_rst && wr_data && cmd_cnt_ff == 4'h0 &&
      io_wdata_i[3:0] == 4'h0;
  endsequence
  a_short_command: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_short_command |=> phase_ff == PH_EXECUTE)
    else $error("one-byte command did not start execution");
  a_late_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_data && phase_ff != PH_COMMAND) |=> $stable(command_ff))
    else $error("command byte taken outside command phase");
  sequence s_last_result;
    phase_ff == PH_EXECUTE && fifo_push && res_cnt_ff == RESULT_BYTES - 4'h1;
  endsequence
  a_irq_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_last_result ##1 (gate && !rd_data && !ctrl_rst) |=> irq_o)
    else $error("no interrupt on completion");
  a_phase_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (phase_ff == PH_RESULT && !ctrl_rst) |=> phase_ff != PH_EXECUTE)
    else $error("phase order broken");
  a_result_order: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (phase_ff == PH_COMMAND && !ctrl_rst) |=> phase_ff != PH_RESULT)
    else $error("results offered before execution");
endmodule
`default_nettype wire

// file: diskette_adapter_pkg.sv
// Shared constants for the diskette adapter control block
package diskette_adapter_pkg;
  localparam logic [9:0] DRIVE_CONTROL_ADDR = 10'h3f2;
  localparam logic [9:0] MAIN_STATUS_ADDR   = 10'h3f4;
  localparam logic [9:0] DATA_STACK_ADDR    = 10'h3f5;
  localparam int SEL_LO_BIT    = 0;
  localparam int SEL_HI_BIT    = 1;
  localparam int NOT_RESET_BIT = 2;
  localparam int REQ_GATE_BIT  = 3;
  localparam int MOTOR_A_BIT   = 4;
  localparam int MOTOR_B_BIT   = 5;
  localparam logic [7:0] DRIVE_CONTROL_RST = 8'h00;
  localparam int MSR_BUSY_BIT = 4;
  localparam int MSR_EXEC_BIT = 5;
  localparam int MSR_DIO_BIT  = 6;
  localparam int MSR_RQM_BIT  = 7;
  localparam int NUM_COMMANDS = 15;
  localparam int DATA_WIDTH   = 8;
  localparam int FIFO_DEPTH   = 32;
  localparam logic [3:0] RESULT_BYTES = 4'h7;
  typedef enum logic [1:0] {PH_COMMAND, PH_EXECUTE, PH_RESULT} phase_e;
endpackage

// file: byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Full comes straight from the occupancy count; empty is the registered head valid
  assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head word held in a register; refilled after each pop
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (!out_valid_o || pop) begin
      if (count_ff > (AW+1)'(pop)) begin
        out_valid_o <= 1'b1;
        out_data_o  <= mem[pop ? rd_ptr_ff + AW'(1) : rd_ptr_ff];
      end else begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: host_model.sv
// Host processor model that drives the adapter's I/O bus and DMA handshake
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       sys_clk_i,
  output var  logic [9:0] io_addr_o,
  output var  logic       io_wr_o,
  output var  logic       io_rd_o,
  output var  logic [7:0] io_wdata_o,
  output var  logic       dma_ack_o,
  output var  logic       disk_index_o
);
  // Bus idle at time zero
  initial begin
    io_addr_o = 10'h000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
    dma_ack_o = 1'b0;
    disk_index_o = 1'b0;
  end
  // One-cycle write; released lines scrambled so a stale value never matches
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~d;
    @(posedge sys_clk_i);
    #1;
  endtask
  // One-cycle read; the answer is judged by the bench monitor
  task automatic rd(input logic [9:0] a);
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    @(posedge sys_clk_i);
    #1;
  endtask
  // Execution byte handshake; gap above one models a slow host
  task automatic ack(input int gap);
    dma_ack_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    dma_ack_o = 1'b0;
    repeat (gap) @(posedge sys_clk_i);
    #1;
  endtask
  // Index pulse from the drive; it also completes an execution byte
  task automatic idx(input int gap);
    disk_index_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    disk_index_o = 1'b0;
    repeat (gap) @(posedge sys_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the diskette adapter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import diskette_adapter_pkg::*;
  logic        sys_clk_i;
  logic        rst_i;
  logic [9:0]  io_addr;
  logic        io_wr, io_rd, dma_ack, disk_index;
  logic [7:0]  io_wdata, io_rdata_o;
  logic        io_rdata_en_o, irq_o, irq_oe_o, dma_req_o, dma_req_oe_o;
  logic        drive_sel_a_o, drive_sel_b_o, motor_a_o, motor_b_o, ctrl_reset_o;
  logic [3:0]  command_code_o;
  int          miscompares = 0;
  int          samples_checked = 0;
  logic [15:0] notes[$];
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  host_model host (.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata), .dma_ack_o(dma_ack), .disk_index_o(disk_index));
  diskette_adapter_control uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata_o),
    .io_rdata_en_o(io_rdata_en_o), .dma_ack_i(dma_ack), .disk_index_i(disk_index),
    .irq_o(irq_o), .irq_oe_o(irq_oe_o), .dma_req_o(dma_req_o), .dma_req_oe_o(dma_req_oe_o),
    .drive_sel_a_o(drive_sel_a_o), .drive_sel_b_o(drive_sel_b_o), .motor_a_o(motor_a_o),
    .motor_b_o(motor_b_o), .ctrl_reset_o(ctrl_reset_o), .command_code_o(command_code_o));
  // Level outputs against a worked-out value
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data against a note holding value and mask
  task automatic chk_read(input logic [7:0] got, input logic [15:0] note);
    samples_checked++;
    if ((got & note[7:0]) !== note[15:8]) begin
      miscompares++;
      $display("unexpected read at %0t: got %h exp %h", $time, got, note[15:8]);
    end
  endtask
  // Every drive output expected from one register value
  task automatic pins(input logic [7:0] d);
    chk_pin({1'b0, motor_a_o, motor_b_o, drive_sel_a_o, drive_sel_b_o, ctrl_reset_o,
      irq_oe_o, dma_req_oe_o}, {1'b0, d[4], d[5], d[1:0] == 2'b00 && d[4],
      d[1:0] == 2'b01 && d[5], ~d[2], d[3], d[3]});
  endtask
  task automatic rdm(input logic [9:0] a, input logic [7:0] exp, input logic [7:0] m);
    notes.push_back({exp, m});
    host.rd(a);
  endtask
  // Answers are paired with the oldest note; an answer without a note is a fault
  always @(posedge sys_clk_i) begin
    if (io_rdata_en_o === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("unexpected answer at %0t: got %h exp %h", $time, io_rdata_o, 8'h00);
      end else begin
        chk_read(io_rdata_o, notes.pop_front());
      end
    end
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    logic [7:0] d;
    logic [3:0] op;
    logic       g;
    logic [3:0] code;
    int         n;
    rst_i = 1'b1;
    void'($urandom(93917));
    repeat (8) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    pins(8'h00);
    // All feature patterns, random upper bits
    for (int i = 0; i < 64; i++) begin
      d = {2'($urandom()), i[5:0]};
      host.wr(DRIVE_CONTROL_ADDR, d);
      pins(d);
    end
    host.rd(DRIVE_CONTROL_ADDR);
    host.rd(10'h3f3);
    // Reset in mid-run must clear a register left with both motors on
    rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    pins(8'h00);
    // Opcodes of each length class, interrupt gate alternating
    for (int k = 0; k < 4; k++) begin
      op = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'h8 : 4'hf;
      g = ~k[0];
      // Opcodes from fifteen up are stored as zero but still take two bytes
      code = (op == 4'hf) ? 4'h0 : op;
      host.wr(DRIVE_CONTROL_ADDR, {4'h1, g, 3'b100});
      host.wr(MAIN_STATUS_ADDR, 8'hff);
      rdm(MAIN_STATUS_ADDR, 8'h80, 8'he0);
      host.wr(DATA_STACK_ADDR, {4'h0, op});
      n = (op == 4'h0) ? 1 : (op < 4'h8) ? 9 : 2;
      for (int j = 1; j < n; j++) host.wr(DATA_STACK_ADDR, 8'($urandom()));
      // A stray byte during execution must not become a new opcode
      host.wr(DATA_STACK_ADDR, 8'h0f);
      chk_pin({4'h0, command_code_o}, {4'h0, code});
      rdm(MAIN_STATUS_ADDR, 8'h30, 8'h30);
      chk_pin({7'h00, dma_req_o & dma_req_oe_o}, {7'h00, g});
      // One command completes its bytes on index pulses instead of acknowledges
      for (int j = 0; j < 7; j++) begin
        if (k == 2) host.idx(1 + ($urandom() % 3));
        else host.ack(1 + ($urandom() % 3));
      end
      repeat (2) @(posedge sys_clk_i);
      #1;
      chk_pin({7'h00, irq_o & irq_oe_o}, {7'h00, g});
      rdm(MAIN_STATUS_ADDR, 8'hc0, 8'he0);
      for (int j = 0; j < 7; j++) rdm(DATA_STACK_ADDR, {code, 4'(j)}, 8'hff);
      rdm(DATA_STACK_ADDR, 8'h00, 8'hff);
      chk_pin({7'h00, irq_o}, 8'h00);
    end
    repeat (4) @(posedge sys_clk_i);
    if (notes.size() != 0) miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
